/* core/lab_pkg.sv */
// constants for the logic array group and its clock path
package lab_pkg;

	// =========================================================
	// structure
	localparam int NUM_CELLS    = 8;
	localparam int NUM_CTRL     = 4;
	localparam int NUM_GLOBALS  = 4;
	localparam int NUM_DED_IN   = 6;
	localparam int LUT_INPUTS   = 4;
	localparam int LUT_SIZE     = 16;

	// =========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CELL_CFG0   = 8'h00;
	localparam logic [7:0] OFF_GROUP_CTRL  = 8'h20;
	localparam logic [7:0] OFF_GLOBAL_CTRL = 8'h24;
	localparam logic [7:0] OFF_LOOP_CTRL   = 8'h28;
	localparam logic [7:0] OFF_OD_CTRL     = 8'h2C;
	localparam logic [7:0] OFF_STATUS      = 8'h30;

	// =========================================================
	// cell configuration word fields
	localparam int CFG_LUT_LSB   = 0;
	localparam int CFG_USE_FF    = 16;
	localparam int CFG_CLK_SEL   = 17;
	localparam int CFG_CLR_EN    = 18;
	localparam int CFG_PRE_EN    = 19;
	localparam int CFG_CARRY     = 20;
	localparam int CFG_CASCADE   = 21;
	localparam int CFG_ENA_EN    = 22;

	// group control: one 6-bit field per shared control
	localparam int CTL_WIDTH     = 6;
	localparam int CTL_SEL_LSB   = 0;
	localparam int CTL_IDX_LSB   = 2;
	localparam int CTL_INV       = 5;

	// source select codes of a shared control
	localparam logic [1:0] SRC_DEDICATED = 2'h0;
	localparam logic [1:0] SRC_GLOBAL    = 2'h1;
	localparam logic [1:0] SRC_IO        = 2'h2;
	localparam logic [1:0] SRC_LOCAL     = 2'h3;

	// global control: one 4-bit field per global signal
	localparam int GLB_WIDTH     = 4;
	localparam int GLB_IDX_LSB   = 0;
	localparam int GLB_INTERNAL  = 3;

	// loop control and status fields
	localparam int LOOP_DESKEW   = 0;
	localparam int LOOP_MULT     = 1;
	localparam int ST_CELLS_LSB  = 0;
	localparam int ST_LOCKED     = 8;
	localparam int ST_PIN_A_OFF  = 9;
	localparam int ST_PERIOD_LSB = 16;

	// =========================================================
	// reset values
	localparam logic [31:0] RST_CELL_CFG    = 32'h0000_0000;
	localparam logic [31:0] RST_GROUP_CTRL  = 32'h0000_0000;
	localparam logic [31:0] RST_GLOBAL_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_LOOP_CTRL   = 32'h0000_0000;
	localparam logic [31:0] RST_OD_CTRL     = 32'h0000_0000;

	// =========================================================
	// clock loop timing, in pclk cycles
	localparam int LOOP_CNT_W       = 8;
	localparam int LOOP_MULT_FACTOR = 2;
	localparam int LOOP_MIN_PERIOD  = 2;
	localparam logic [LOOP_CNT_W-1:0] LOOP_CNT_MAX = 8'hFF;

	typedef enum logic [1:0] {
		LOOP_OFF    = 2'b00,
		LOOP_ACQ    = 2'b01,
		LOOP_LOCKED = 2'b10
	} loop_state_t;

endpackage : lab_pkg

/* core/logic_cell.sv */
// one logic cell: lookup table, carry and cascade, flip-flop
`timescale 1ns/100ps
module logic_cell
	import lab_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] cfg,
	input  wire logic [3:0]  data,
	input  wire logic        carry_in,
	input  wire logic        cascade_in,
	input  wire logic        clk_tick,
	input  wire logic        clr,
	input  wire logic        pre,
	output logic             cell_out,
	output logic             carry_out,
	output logic             cascade_out
);
	logic [LUT_SIZE-1:0] lut_mask;
	logic [3:0]          lut_in;
	logic                lut_val;
	logic                ena;
	logic                q;

	assign lut_mask = cfg[CFG_LUT_LSB +: LUT_SIZE];
	// carry mode replaces the third input with the chain
	assign lut_in = {data[3], cfg[CFG_CARRY] ? carry_in : data[2],
		data[1], data[0]};
	assign lut_val = lut_mask[lut_in];
	assign carry_out = cfg[CFG_CARRY] &
		((data[0] & data[1]) | (carry_in & (data[0] ^ data[1])));
	assign cascade_out = cfg[CFG_CASCADE] ? (lut_val & cascade_in)
		: lut_val;
	assign ena = cfg[CFG_ENA_EN] ? data[3] : 1'b1;
	assign cell_out = cfg[CFG_USE_FF] ? q : cascade_out;

	// clear and preset win over the clock tick and the enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 1'b0;
		end else if (clr) begin
			q <= 1'b0;
		end else if (pre) begin
			q <= 1'b1;
		end else if (clk_tick && ena) begin
			q <= cascade_out;
		end
	end

endmodule : logic_cell

/* core/lab_logic_cell_and_clock_path.sv */
// logic array group with shared controls, globals, clock loop, pins
`timescale 1ns/100ps
module lab_logic_cell_and_clock_path
	import lab_pkg::*;
#(
	parameter int MEM_AW = 4,
	parameter int MEM_DW = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	input  wire logic              clock_pin_a,
	input  wire logic              clock_pin_b,
	input  wire logic [3:0]        global_pin,
	input  wire logic [31:0]       cell_data,
	input  wire logic              carry_chain_in,
	input  wire logic              cascade_chain_in,
	output logic                   carry_chain_out,
	output logic                   cascade_chain_out,
	output logic [7:0]             row_col_out,
	input  wire logic [7:0]        pad_in,
	output logic [7:0]             pad_out,
	output logic [7:0]             pad_oe_n,
	input  wire logic              mem_we,
	input  wire logic [MEM_AW-1:0] mem_addr,
	input  wire logic [MEM_DW-1:0] mem_wdata,
	output logic [MEM_DW-1:0]      mem_rdata
);
	// =========================================================
	// elaboration checks
	if (MEM_AW < 1 || MEM_AW > 12 || MEM_DW < 1 || MEM_DW > 32) begin : g_chk
		$error("memory size parameters out of range");
	end

	// =========================================================
	// shared functions
	function automatic logic pick_src(
		input logic [5:0] fld,
		input logic       ded,
		input logic [3:0] glob,
		input logic [7:0] io,
		input logic [7:0] loc
	);
		logic [2:0] idx;
		logic       v;
		idx = fld[CTL_IDX_LSB +: 3];
		unique case (fld[CTL_SEL_LSB +: 2])
			SRC_DEDICATED: v = ded;
			SRC_GLOBAL:    v = glob[idx[1:0]];
			SRC_IO:        v = io[idx];
			SRC_LOCAL:     v = loc[idx];
		endcase
		return v;
	endfunction : pick_src

	// =========================================================
	// registers
	logic [31:0]     cell_cfg [NUM_CELLS];
	logic [31:0]     group_ctrl;
	logic [31:0]     global_ctrl;
	logic [31:0]     loop_ctrl;
	logic [7:0]      od_ctrl;
	logic            setup_ph;
	logic            wr_access;
	logic [5:0]      word_idx;
	logic            is_cell;
	logic            mapped;
	logic [31:0]     rd_mux;
	logic [31:0]     status_word;

	assign setup_ph  = psel & ~penable;
	assign wr_access = psel & penable & pready & pwrite & ~pslverr;
	assign word_idx  = paddr[7:2];
	assign is_cell   = paddr < OFF_GROUP_CTRL;
	assign mapped    = (paddr[1:0] == 2'h0) && (paddr <= OFF_STATUS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CELLS; i++) begin
				cell_cfg[i] <= RST_CELL_CFG;
			end
			group_ctrl  <= RST_GROUP_CTRL;
			global_ctrl <= RST_GLOBAL_CTRL;
			loop_ctrl   <= RST_LOOP_CTRL;
			od_ctrl     <= RST_OD_CTRL[7:0];
		end else if (wr_access) begin
			if (is_cell) begin
				cell_cfg[word_idx[2:0]] <= pwdata;
			end else if (paddr == OFF_GROUP_CTRL) begin
				group_ctrl <= pwdata;
			end else if (paddr == OFF_GLOBAL_CTRL) begin
				global_ctrl <= pwdata;
			end else if (paddr == OFF_LOOP_CTRL) begin
				loop_ctrl <= pwdata;
			end else if (paddr == OFF_OD_CTRL) begin
				od_ctrl <= pwdata[7:0];
			end
		end
	end

	// =========================================================
	// apb answer: one access cycle, no wait states
	assign rd_mux =
		is_cell                      ? cell_cfg[word_idx[2:0]] :
		(paddr == OFF_GROUP_CTRL)    ? group_ctrl :
		(paddr == OFF_GLOBAL_CTRL)   ? global_ctrl :
		(paddr == OFF_LOOP_CTRL)     ? loop_ctrl :
		(paddr == OFF_OD_CTRL)       ? {24'h00_0000, od_ctrl} :
		status_word;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			if (setup_ph) begin
				prdata <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
			end
		end
	end

	// =========================================================
	// clock loop on pin b: lock, deskew and double
	loop_state_t             loop_state;
	loop_state_t             next_loop_state;
	logic                    ref_prev;
	logic                    ref_rise;
	logic [LOOP_CNT_W-1:0]   loop_cnt;
	logic [LOOP_CNT_W-1:0]   loop_period;
	logic [LOOP_CNT_W-1:0]   period_meas;
	logic [LOOP_CNT_W-1:0]   min_period;
	logic                    deskew_en;
	logic                    mult_en;
	logic                    loop_on;
	logic                    locked;
	logic                    in_range;
	logic                    loop_tick;
	logic                    pin_a_off;

	assign deskew_en   = loop_ctrl[LOOP_DESKEW];
	assign mult_en     = loop_ctrl[LOOP_MULT];
	assign loop_on     = deskew_en | mult_en;
	assign ref_rise    = clock_pin_b & ~ref_prev;
	assign period_meas = loop_cnt + LOOP_CNT_W'(1);
	// doubling needs a longer reference period
	assign min_period  = mult_en
		? LOOP_CNT_W'(LOOP_MIN_PERIOD * LOOP_MULT_FACTOR)
		: LOOP_CNT_W'(LOOP_MIN_PERIOD);
	assign in_range    = (period_meas >= min_period) &&
		(loop_cnt != LOOP_CNT_MAX);
	assign locked      = loop_state == LOOP_LOCKED;
	// edge tick plus a mid-period tick when doubling
	assign loop_tick   = locked & (ref_rise | (mult_en & ~ref_rise &
		(loop_cnt == (loop_period >> 1) - LOOP_CNT_W'(1))));
	assign pin_a_off   = deskew_en & mult_en;

	always_comb begin
		next_loop_state = loop_state;
		unique case (loop_state)
			LOOP_OFF: begin
				if (loop_on) next_loop_state = LOOP_ACQ;
			end
			LOOP_ACQ: begin
				if (ref_rise && in_range && period_meas == loop_period)
					next_loop_state = LOOP_LOCKED;
			end
			LOOP_LOCKED: begin
				if ((ref_rise && (!in_range || period_meas != loop_period))
					|| loop_cnt == LOOP_CNT_MAX)
					next_loop_state = LOOP_ACQ;
			end
			default: next_loop_state = LOOP_OFF;
		endcase
		if (!loop_on) next_loop_state = LOOP_OFF;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_state  <= LOOP_OFF;
			ref_prev    <= 1'b0;
			loop_cnt    <= '0;
			loop_period <= '0;
		end else begin
			loop_state <= next_loop_state;
			ref_prev   <= clock_pin_b;
			if (!loop_on || ref_rise) begin
				loop_cnt <= '0;
			end else if (loop_cnt != LOOP_CNT_MAX) begin
				loop_cnt <= period_meas;
			end
			if (ref_rise) loop_period <= period_meas;
		end
	end

	// =========================================================
	// globals and shared controls
	logic [7:0]  local_bus;
	logic [3:0]  globals;
	logic        ded_clk [2];
	logic        ctl_raw [NUM_CTRL];
	logic        ctl     [NUM_CTRL];
	logic        blk_clk_prev [2];
	logic        blk_tick [2];
	logic        blk_loop [2];

	// each dedicated input or a cell output drives a global
	for (genvar g = 0; g < NUM_GLOBALS; g++) begin : g_glob
		assign globals[g] = global_ctrl[g*GLB_WIDTH + GLB_INTERNAL]
			? local_bus[global_ctrl[g*GLB_WIDTH + GLB_IDX_LSB +: 3]]
			: global_pin[g];
	end

	// pin a blocked under deskew plus multiply; pin b feeds only the loop while the loop runs
	assign ded_clk[0] = pin_a_off ? 1'b0 : clock_pin_a;
	assign ded_clk[1] = loop_on ? 1'b0 : clock_pin_b;

	for (genvar c = 0; c < NUM_CTRL; c++) begin : g_ctl
		logic [5:0] fld;
		assign fld = group_ctrl[c*CTL_WIDTH +: CTL_WIDTH];
		if (c < 2) begin : g_clk
			assign ctl_raw[c] = pick_src(fld, ded_clk[c], globals,
				pad_in, local_bus);
			assign blk_loop[c] = loop_on && c == 1 &&
				fld[CTL_SEL_LSB +: 2] == SRC_DEDICATED;
		end else begin : g_cp
			// no dedicated clock pin may source clear or preset
			assign ctl_raw[c] = pick_src(fld, 1'b0, globals,
				pad_in, local_bus);
		end
		assign ctl[c] = ctl_raw[c] ^ fld[CTL_INV];
	end

	// block clocks become rising-edge ticks; loop tick passes straight
	for (genvar k = 0; k < 2; k++) begin : g_tick
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) blk_clk_prev[k] <= 1'b0;
			else          blk_clk_prev[k] <= ctl[k];
		end
		assign blk_tick[k] = blk_loop[k] ? loop_tick
			: (ctl[k] & ~blk_clk_prev[k]);
	end

	// =========================================================
	// eight logic cells on carry and cascade chains
	logic [NUM_CELLS:0] carry_link;
	logic [NUM_CELLS:0] cascade_link;

	assign carry_link[0]   = carry_chain_in;
	assign cascade_link[0] = cascade_chain_in;

	for (genvar n = 0; n < NUM_CELLS; n++) begin : g_cell
		logic [31:0] cfg;
		assign cfg = cell_cfg[n];
		logic_cell u_cell (
			.pclk        (pclk),
			.presetn     (presetn),
			.cfg         (cfg),
			.data        (cell_data[n*LUT_INPUTS +: LUT_INPUTS]),
			.carry_in    (carry_link[n]),
			.cascade_in  (cascade_link[n]),
			.clk_tick    (blk_tick[cfg[CFG_CLK_SEL]]),
			.clr         (cfg[CFG_CLR_EN] & ctl[2]),
			.pre         (cfg[CFG_PRE_EN] & ctl[3]),
			.cell_out    (local_bus[n]),
			.carry_out   (carry_link[n+1]),
			.cascade_out (cascade_link[n+1])
		);
	end

	assign status_word = {8'h00, loop_period, 6'h00, pin_a_off, locked,
		row_col_out};

	// =========================================================
	// registered outputs, open-drain pins and memory
	logic [MEM_DW-1:0] mem_array [2**MEM_AW];
	logic              mem_we_q;
	logic [MEM_AW-1:0] mem_addr_q;
	logic [MEM_DW-1:0] mem_wdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			row_col_out       <= 8'h00;
			carry_chain_out   <= 1'b0;
			cascade_chain_out <= 1'b0;
			pad_out           <= 8'h00;
			pad_oe_n          <= 8'hFF;
		end else begin
			row_col_out       <= local_bus;
			carry_chain_out   <= carry_link[NUM_CELLS];
			cascade_chain_out <= cascade_link[NUM_CELLS];
			// open drain: drive low for a 0, float for a 1
			pad_out  <= local_bus & ~od_ctrl;
			pad_oe_n <= od_ctrl & local_bus;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_we_q    <= 1'b0;
			mem_addr_q  <= '0;
			mem_wdata_q <= '0;
			mem_rdata   <= '0;
		end else begin
			mem_we_q    <= mem_we;
			mem_addr_q  <= mem_addr;
			mem_wdata_q <= mem_wdata;
			mem_rdata   <= mem_array[mem_addr_q];
		end
	end

	always_ff @(posedge pclk) begin
		if (mem_we_q) mem_array[mem_addr_q] <= mem_wdata_q;
	end

endmodule : lab_logic_cell_and_clock_path

/* bench/lab_props.sv */
// checker for the logic array group ports
`timescale 1ns/100ps
module lab_props
	import lab_pkg::*;
#(
	parameter int MEM_AW = 4,
	parameter int MEM_DW = 8
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [31:0]       prdata,
	input wire logic [7:0]        row_col_out,
	input wire logic [7:0]        pad_out,
	input wire logic [7:0]        pad_oe_n,
	input wire logic              mem_we,
	input wire logic [MEM_AW-1:0] mem_addr,
	input wire logic [MEM_DW-1:0] mem_wdata,
	input wire logic [MEM_DW-1:0] mem_rdata
);
	// =========================================================
	// shadow of the open-drain enables, one cycle history
	logic [7:0] od;
	logic [7:0] od_prev;
	logic       up;
	wire        od_wr = psel && penable && pready && pwrite && !pslverr
		&& paddr == OFF_OD_CTRL;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			od <= 8'h00;
			od_prev <= 8'h00;
			up <= 1'b0;
		end else begin
			od <= od_wr ? pwdata[7:0] : od;
			od_prev <= od;
			up <= 1'b1;
		end
	end

	// =========================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	err_addr_a: assert property (psel && !penable
		&& (paddr[1:0] != 2'b00 || paddr > OFF_STATUS) |=> pslverr)
		else $error("bad address not refused");
	mapped_ok_a: assert property (psel && !penable && paddr[1:0] == 2'b00
		&& paddr <= OFF_STATUS |=> pready && !pslverr)
		else $error("mapped address refused");
	err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("refused access carries data");
	od_float_a: assert property (up && od == od_prev |->
		pad_oe_n == (od & row_col_out))
		else $error("pad enable wrong");
	od_drive_a: assert property (up && od == od_prev |->
		pad_out == (row_col_out & ~od))
		else $error("open-drain pad driven high");
	mem_latency_a: assert property (mem_we ##1 (!mem_we
		&& mem_addr == $past(mem_addr)) |-> ##2 mem_rdata == $past(mem_wdata, 3))
		else $error("memory read latency or data wrong");

	cover property (pslverr);
	cover property (mem_we ##1 !mem_we);
	cover property (|(od & pad_oe_n));
endmodule : lab_props

bind lab_logic_cell_and_clock_path lab_props #(
	.MEM_AW(MEM_AW),
	.MEM_DW(MEM_DW)
) lab_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .prdata, .row_col_out, .pad_out, .pad_oe_n,
	.mem_we, .mem_addr, .mem_wdata, .mem_rdata);

/* bench/far_logic.sv */
// far-side logic: loop reference source, io drivers and pulled-up pads
`timescale 1ns/100ps
module far_logic #(
	parameter int REF_HALF = 4
) (
	input  wire logic       pclk,
	input  wire logic       ref_run,
	input  wire logic [7:0] io_drive,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe_n,
	output logic            clock_pin_b,
	output logic [7:0]      pad_in,
	output logic [7:0]      pad_wire
);
	int cnt = 0;

	initial clock_pin_b = 1'b0;

	// =========================================================
	// reference stands low outside runs
	always @(posedge pclk) begin
		if (!ref_run) begin
			cnt <= 0;
			clock_pin_b <= 1'b0;
		end else if (cnt == REF_HALF - 1) begin
			cnt <= 0;
			clock_pin_b <= ~clock_pin_b;
		end else begin
			cnt <= cnt + 1;
		end
	end

	// released pads read high through the pull-up
	assign pad_wire = (pad_out & ~pad_oe_n) | pad_oe_n;
	assign pad_in = io_drive;
endmodule : far_logic

/* bench/testbench.sv */
// self-checking bench for the logic array group
`timescale 1ns/100ps
module testbench;
	import lab_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, row_col_out, pad_in, pad_out, pad_oe_n, pad_wire;
	logic [31:0] pwdata, prdata, cell_data;
	logic        clock_pin_a, clock_pin_b, ref_run, mem_we;
	logic        carry_chain_in, cascade_chain_in;
	logic        carry_chain_out, cascade_chain_out;
	logic [3:0]  global_pin, mem_addr;
	logic [7:0]  io_drive, mem_wdata, mem_rdata;
	int          failures, total_checks;

	lab_logic_cell_and_clock_path lab_logic_cell_and_clock_path_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .clock_pin_a, .clock_pin_b, .global_pin,
		.cell_data, .carry_chain_in, .cascade_chain_in, .carry_chain_out,
		.cascade_chain_out, .row_col_out, .pad_in,
		.pad_out, .pad_oe_n, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);

	far_logic far_logic_inst (.pclk, .ref_run, .io_drive, .pad_out,
		.pad_oe_n, .clock_pin_b, .pad_in, .pad_wire);

	always #2.5 pclk = ~pclk;

	// =========================================================
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic settle(int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : settle

	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			check("apb answer", 32'h0000_0000, 32'h0000_0001);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rdc(string name, logic [7:0] a, logic [31:0] m,
		logic [31:0] e);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		check(name, rd & m, e);
	endtask : rdc

	// pulse one control source high for three cycles
	task automatic strobe(int k);
		for (int lv = 1; lv >= 0; lv--) begin
			@(posedge pclk);
			case (k)
				0: clock_pin_a <= 1'(lv);
				1: global_pin[0] <= 1'(lv);
				2: io_drive[1] <= 1'(lv);
				default: cell_data[7] <= 1'(lv);
			endcase
			repeat (2) @(posedge pclk);
		end
		settle(3);
	endtask : strobe

	task automatic step(int k, logic e, string name);
		strobe(k);
		check(name, 32'(row_col_out[0]), 32'(e));
	endtask : step

	// =========================================================
	task automatic t_regs();
		logic [31:0] rd;
		logic        err;
		for (int i = 0; i < 12; i++)
			rdc("reset value", 8'(4 * i), 32'hFFFF_FFFF, 32'h0000_0000);
		wr(OFF_GROUP_CTRL, 32'h0018_1000);
		apb(1'b0, 8'h34, 32'h0000_0000, rd, err);
		check("unmapped refused", 32'(err), 32'h0000_0001);
		apb(1'b1, 8'h06, 32'hFFFF_FFFF, rd, err);
		check("misaligned refused", 32'(err), 32'h0000_0001);
		rdc("misaligned ignored", 8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
		rdc("group ctrl", OFF_GROUP_CTRL, 32'hFFFF_FFFF, 32'h0018_1000);
		$display("test regs finished");
	endtask : t_regs

	task automatic t_lut();
		logic [15:0] m [8];
		logic [7:0]  e;
		for (int c = 0; c < 8; c++) begin
			m[c] = 16'h6996 ^ 16'(c * 16'h0F1D);
			wr(8'(4 * c), {16'h0000, m[c]});
		end
		for (int v = 0; v < 16; v++) begin
			@(posedge pclk);
			cell_data <= {8{4'(v)}};
			settle(2);
			for (int c = 0; c < 8; c++)
				e[c] = m[c][v];
			check("lut outputs", 32'(row_col_out), 32'(e));
		end
		$display("test lut finished");
	endtask : t_lut

	task automatic t_flop();
		wr(OFF_CELL_CFG0, 32'h000D_FFFF);
		cell_data <= 32'h0000_0000;
		settle(3);
		check("flop idle", 32'(row_col_out[0]), 32'h0000_0000);
		step(0, 1'b1, "pin clock");
		step(1, 1'b0, "global clear");
		step(2, 1'b1, "io preset");
		wr(OFF_CELL_CFG0 + 8'h04, 32'h0000_FF00);
		wr(OFF_GLOBAL_CTRL, 32'h0000_0009);
		step(3, 1'b0, "cell global clear");
		wr(OFF_GLOBAL_CTRL, 32'h0000_0000);
		wr(OFF_CELL_CFG0, 32'h004D_FFFF);
		step(2, 1'b1, "preset no enable");
		step(1, 1'b0, "clear no enable");
		step(0, 1'b0, "clock no enable");
		@(posedge pclk) cell_data[3] <= 1'b1;
		step(0, 1'b1, "clock enabled");
		wr(OFF_GROUP_CTRL, 32'h001A_1000);
		step(0, 1'b0, "inverted clear");
		wr(OFF_GROUP_CTRL, 32'h0018_1007);
		step(3, 1'b1, "local clock");
		wr(OFF_GROUP_CTRL, 32'h0018_1000);
		step(1, 1'b0, "clear again");
		$display("test flop finished");
	endtask : t_flop

	task automatic t_loop();
		wr(OFF_CELL_CFG0, 32'h000D_FFFF);
		wr(OFF_LOOP_CTRL, 32'h0000_0003);
		ref_run <= 1'b1;
		settle(80);
		rdc("loop status", OFF_STATUS, 32'h00FF_0300, 32'h0008_0300);
		step(0, 1'b0, "pin a blocked");
		wr(OFF_CELL_CFG0, 32'h000F_FFFF);
		settle(20);
		check("loop clock", 32'(row_col_out[0]), 32'h0000_0001);
		wr(OFF_LOOP_CTRL, 32'h0000_0000);
		ref_run <= 1'b0;
		settle(4);
		rdc("loop off", OFF_STATUS, 32'h0000_0300, 32'h0000_0000);
		$display("test loop finished");
	endtask : t_loop

	task automatic t_od();
		wr(OFF_CELL_CFG0, 32'h0000_0002);
		wr(OFF_OD_CTRL, 32'h0000_0001);
		for (int v = 0; v < 2; v++) begin
			@(posedge pclk);
			cell_data <= 32'(v);
			settle(3);
			check("pad level", 32'(pad_wire[0]), 32'(v));
			check("pad data", 32'(pad_out[0]), 32'h0000_0000);
		end
		wr(OFF_OD_CTRL, 32'h0000_0000);
		settle(3);
		check("push pull", 32'({pad_oe_n[0], pad_out[0]}), 32'h0000_0001);
		$display("test open drain finished");
	endtask : t_od

	task automatic t_mem();
		logic [7:0] d [2] = '{8'hA5, 8'h3C};
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			mem_we <= (i % 2 == 0);
			mem_addr <= 4'(3 + 2 * (i / 2));
			mem_wdata <= d[i / 2];
			if (i % 2 == 1) begin
				settle(3);
				check("memory read", 32'(mem_rdata), 32'(d[i / 2]));
			end
		end
		$display("test memory finished");
	endtask : t_mem

	task automatic t_chain();
		for (int c = 0; c < 8; c++)
			wr(8'(4 * c), 32'h0030_FFFF);
		// propagate with chain in low, then high, then generate
		for (int v = 0; v < 3; v++) begin
			@(posedge pclk);
			cell_data <= (v == 2) ? 32'h3333_3333 : 32'h1111_1111;
			carry_chain_in <= (v == 1);
			cascade_chain_in <= (v == 1);
			settle(2);
			check("carry", 32'(carry_chain_out), 32'(v != 0));
			check("cascade", 32'(cascade_chain_out), 32'(v == 1));
		end
		$display("test chains finished");
	endtask : t_chain

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// =========================================================
	initial begin
		{pclk, presetn, psel, penable, pwrite, clock_pin_a} = 6'h00;
		{ref_run, mem_we, paddr, pwdata, cell_data} = 74'h0;
		{global_pin, mem_addr, io_drive, mem_wdata} = 24'h00_0000;
		{carry_chain_in, cascade_chain_in} = 2'h0;
		failures = 0;
		total_checks = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_lut();
		t_flop();
		t_loop();
		t_od();
		t_mem();
		t_chain();
		end_of_test();
	end

	// whole run needs a few hundred cycles
	initial begin
		#100000;
		failures++;
		end_of_test();
	end
endmodule : testbench
